// ### src/async_serial_receiver_pkg.sv
package async_serial_receiver_pkg;

	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_INTERRUPT_CONTROL = 10'h00b;
	localparam logic [9:0] IDX_PERIPHERAL_IRQ_FLAGS = 10'h00c;
	localparam logic [9:0] IDX_RX_STATUS_CONTROL = 10'h018;
	localparam logic [9:0] IDX_RX_DATA_BUFFER = 10'h01a;
	localparam logic [9:0] IDX_PERIPHERAL_IRQ_ENABLES = 10'h08c;
	localparam logic [9:0] IDX_TX_STATUS_CONTROL = 10'h098;
	localparam logic [9:0] IDX_BAUD_DIVISOR = 10'h099;

	localparam int ADDR_W = 12;

	// Reset values
	localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
	localparam logic [7:0] RST_RX_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] RST_PERIPHERAL_IRQ_ENABLES = 8'h00;
	localparam logic [7:0] RST_TX_STATUS_CONTROL = 8'h02;
	localparam logic [7:0] RST_BAUD_DIVISOR = 8'h00;

	// Software-writable bits
	localparam logic [7:0] WMASK_RX_STATUS_CONTROL = 8'hf8;
	localparam logic [7:0] WMASK_TX_STATUS_CONTROL = 8'hf5;

	// rx_status_control fields
	localparam int SERIAL_PORT_ENABLE_BIT = 7;
	localparam int NINE_BIT_RX_ENABLE_BIT = 6;
	localparam int CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
	localparam int ADDRESS_DETECT_ENABLE_BIT = 3;
	// tx_status_control fields
	localparam int SYNC_MODE_BIT = 4;
	localparam int HIGH_SPEED_BAUD_BIT = 2;
	localparam int TX_SHIFT_EMPTY_BIT = 1;
	// Receive flag and enable position
	localparam int RX_READY_FLAG_BIT = 5;
	localparam int RX_IRQ_ENABLE_BIT = 5;

	// Oversampling
	localparam logic [3:0] OVS_MID = 4'h7;
	localparam logic [3:0] OVS_LAST = 4'hf;
	localparam logic [1:0] PRESCALE_LAST = 2'h3;
	localparam logic [3:0] BITS_EIGHT = 4'h8;
	localparam logic [3:0] BITS_NINE = 4'h9;

	localparam logic [1:0] FIFO_DEPTH = 2'h2;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_DATA = 2'b11,
		ST_STOP = 2'b10
	} rx_state_t;

endpackage

// ### src/async_serial_receiver.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module async_serial_receiver (
	input wire logic clk,
	input wire logic srst,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial_rx_pin,
	input wire logic sleep_mode,
	output logic rx_irq_req
);

	function automatic logic [9:0] reg_index(input logic [11:0] addr);
		reg_index = addr[11:2];
	endfunction

	logic [7:0] interrupt_control_q, interrupt_control_d;
	logic [7:0] rx_status_control_q, rx_status_control_d;
	logic [7:0] pie_q, pie_d;
	logic [7:0] tx_status_control_q, tx_status_control_d;
	logic [7:0] baud_q, baud_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [1:0] rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;

	async_serial_receiver_pkg::rx_state_t st_q, st_d;
	logic [3:0] os_q, os_d;
	logic [3:0] bits_q, bits_d;
	logic [8:0] sr_q, sr_d;
	logic prev_q, prev_d;
	logic [7:0] brg_q, brg_d;
	logic [1:0] pre_q, pre_d;
	logic overrun_error_q, overrun_error_d;
	logic wp_q, wp_d;
	logic rp_q, rp_d;
	logic [1:0] cnt_q, cnt_d;
	logic [9:0] mem [0:1];

	logic wr_go;
	logic rd_go;
	logic pop;
	logic push;
	logic [9:0] push_word;
	logic [9:0] head;
	logic rx_ready_flag;
	logic rx_on;
	logic [8:0] word9;
	logic [3:0] nbits;
	logic tick;
	logic brg_tick;

	assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
	assign rd_go = s_axi_arvalid & ~rvalid_q;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	// Head entry; empty FIFO shows zeros
	assign head = (cnt_q != 2'h0) ? mem[rp_q] : 10'h000;
	assign rx_ready_flag = (cnt_q != 2'h0);
	assign rx_irq_req = rx_ready_flag
		& pie_q[async_serial_receiver_pkg::RX_IRQ_ENABLE_BIT];
	assign pop = rd_go && (reg_index(s_axi_araddr) == async_serial_receiver_pkg::IDX_RX_DATA_BUFFER)
		&& (cnt_q != 2'h0);
	assign rx_on = rx_status_control_q[async_serial_receiver_pkg::SERIAL_PORT_ENABLE_BIT]
		& rx_status_control_q[async_serial_receiver_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT]
		& ~tx_status_control_q[async_serial_receiver_pkg::SYNC_MODE_BIT]
		& ~sleep_mode;
	assign nbits = rx_status_control_q[async_serial_receiver_pkg::NINE_BIT_RX_ENABLE_BIT]
		? async_serial_receiver_pkg::BITS_NINE : async_serial_receiver_pkg::BITS_EIGHT;
	// Shifting right from the top leaves an 8-bit word in the upper bits
	assign word9 = rx_status_control_q[async_serial_receiver_pkg::NINE_BIT_RX_ENABLE_BIT]
		? sr_q : {1'b0, sr_q[8:1]};
	assign brg_tick = rx_on && (brg_q == 8'h00);
	// Slow mode divides the x64 clock down to x16 sample ticks
	assign tick = brg_tick && (tx_status_control_q[async_serial_receiver_pkg::HIGH_SPEED_BAUD_BIT]
		|| (pre_q == async_serial_receiver_pkg::PRESCALE_LAST));

	always_comb
	begin
		interrupt_control_d = interrupt_control_q;
		rx_status_control_d = rx_status_control_q;
		pie_d = pie_q;
		tx_status_control_d = tx_status_control_q;
		baud_d = baud_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (bvalid_q && s_axi_bready)
		begin
			bvalid_d = 1'b0;
		end
		if (wr_go)
		begin
			bvalid_d = 1'b1;
			bresp_d = async_serial_receiver_pkg::RESP_OKAY;
			case (reg_index(s_axi_awaddr))
				async_serial_receiver_pkg::IDX_INTERRUPT_CONTROL:
				begin
					if (s_axi_wstrb[0])
						interrupt_control_d = s_axi_wdata[7:0];
				end
				async_serial_receiver_pkg::IDX_RX_STATUS_CONTROL:
				begin
					// Error and ninth-bit fields are hardware-owned
					if (s_axi_wstrb[0])
						rx_status_control_d = s_axi_wdata[7:0]
							& async_serial_receiver_pkg::WMASK_RX_STATUS_CONTROL;
				end
				async_serial_receiver_pkg::IDX_PERIPHERAL_IRQ_ENABLES:
				begin
					if (s_axi_wstrb[0])
						pie_d = s_axi_wdata[7:0];
				end
				async_serial_receiver_pkg::IDX_TX_STATUS_CONTROL:
				begin
					if (s_axi_wstrb[0])
						tx_status_control_d = s_axi_wdata[7:0]
							& async_serial_receiver_pkg::WMASK_TX_STATUS_CONTROL;
				end
				async_serial_receiver_pkg::IDX_BAUD_DIVISOR:
				begin
					if (s_axi_wstrb[0])
						baud_d = s_axi_wdata[7:0];
				end
				// Flag and data buffer ignore writes
				async_serial_receiver_pkg::IDX_PERIPHERAL_IRQ_FLAGS,
				async_serial_receiver_pkg::IDX_RX_DATA_BUFFER:
				begin
					bresp_d = async_serial_receiver_pkg::RESP_OKAY;
				end
				default:
				begin
					bresp_d = async_serial_receiver_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (rvalid_q && s_axi_rready)
		begin
			rvalid_d = 1'b0;
		end
		if (rd_go)
		begin
			rvalid_d = 1'b1;
			rresp_d = async_serial_receiver_pkg::RESP_OKAY;
			rdata_d = 32'h00000000;
			case (reg_index(s_axi_araddr))
				async_serial_receiver_pkg::IDX_INTERRUPT_CONTROL:
					rdata_d[7:0] = interrupt_control_q;
				async_serial_receiver_pkg::IDX_PERIPHERAL_IRQ_FLAGS:
					rdata_d[async_serial_receiver_pkg::RX_READY_FLAG_BIT] = rx_ready_flag;
				async_serial_receiver_pkg::IDX_RX_STATUS_CONTROL:
					rdata_d[7:0] = {rx_status_control_q[7:3], head[9], overrun_error_q, head[8]};
				async_serial_receiver_pkg::IDX_RX_DATA_BUFFER:
					rdata_d[7:0] = head[7:0];
				async_serial_receiver_pkg::IDX_PERIPHERAL_IRQ_ENABLES:
					rdata_d[7:0] = pie_q;
				async_serial_receiver_pkg::IDX_TX_STATUS_CONTROL:
				begin
					// No transmitter here, so its shifter always reads empty
					rdata_d[7:0] = tx_status_control_q;
					rdata_d[async_serial_receiver_pkg::TX_SHIFT_EMPTY_BIT] = 1'b1;
				end
				async_serial_receiver_pkg::IDX_BAUD_DIVISOR:
					rdata_d[7:0] = baud_q;
				default:
					rresp_d = async_serial_receiver_pkg::RESP_SLVERR;
			endcase
		end
	end

	always_comb
	begin
		st_d = st_q;
		os_d = os_q;
		bits_d = bits_q;
		sr_d = sr_q;
		prev_d = serial_rx_pin;
		brg_d = brg_q;
		pre_d = pre_q;
		overrun_error_d = overrun_error_q;
		push = 1'b0;
		push_word = 10'h000;
		if (!rx_status_control_q[async_serial_receiver_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT])
		begin
			overrun_error_d = 1'b0;
		end
		if (!rx_on)
		begin
			st_d = async_serial_receiver_pkg::ST_IDLE;
			os_d = 4'h0;
			bits_d = 4'h0;
			brg_d = baud_q;
			pre_d = 2'h0;
		end
		else
		begin
			if (brg_tick)
			begin
				brg_d = baud_q;
				pre_d = pre_q + 2'h1;
			end
			else
			begin
				brg_d = brg_q - 8'h01;
			end
			case (st_q)
				async_serial_receiver_pkg::ST_IDLE:
				begin
					if (prev_q && !serial_rx_pin)
					begin
						st_d = async_serial_receiver_pkg::ST_START;
						os_d = 4'h0;
					end
				end
				async_serial_receiver_pkg::ST_START:
				begin
					if (tick)
					begin
						os_d = os_q + 4'h1;
						if (os_q == async_serial_receiver_pkg::OVS_MID)
						begin
							// A glitch that is high again mid-bit is no start
							os_d = 4'h0;
							bits_d = 4'h0;
							st_d = serial_rx_pin ? async_serial_receiver_pkg::ST_IDLE
								: async_serial_receiver_pkg::ST_DATA;
						end
					end
				end
				async_serial_receiver_pkg::ST_DATA:
				begin
					if (tick)
					begin
						os_d = os_q + 4'h1;
						if (os_q == async_serial_receiver_pkg::OVS_LAST)
						begin
							sr_d = {serial_rx_pin, sr_q[8:1]};
							bits_d = bits_q + 4'h1;
							if (bits_q + 4'h1 == nbits)
								st_d = async_serial_receiver_pkg::ST_STOP;
						end
					end
				end
				async_serial_receiver_pkg::ST_STOP:
				begin
					if (tick)
					begin
						os_d = os_q + 4'h1;
						if (os_q == async_serial_receiver_pkg::OVS_LAST)
						begin
							st_d = async_serial_receiver_pkg::ST_IDLE;
							// Data words skipped under address detect never raise the flag
							if (!(rx_status_control_q[async_serial_receiver_pkg::NINE_BIT_RX_ENABLE_BIT]
								&& rx_status_control_q[async_serial_receiver_pkg::ADDRESS_DETECT_ENABLE_BIT]
								&& !word9[8]))
							begin
								if (overrun_error_q)
									push = 1'b0;
								else if (cnt_q == async_serial_receiver_pkg::FIFO_DEPTH)
									overrun_error_d = 1'b1;
								else
								begin
									push = 1'b1;
									push_word = {~serial_rx_pin, word9};
								end
							end
						end
					end
				end
				default:
				begin
					st_d = async_serial_receiver_pkg::ST_IDLE;
				end
			endcase
		end
		wp_d = wp_q ^ push;
		rp_d = rp_q ^ pop;
		cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			interrupt_control_q <= async_serial_receiver_pkg::RST_INTERRUPT_CONTROL;
			rx_status_control_q <= async_serial_receiver_pkg::RST_RX_STATUS_CONTROL;
			pie_q <= async_serial_receiver_pkg::RST_PERIPHERAL_IRQ_ENABLES;
			tx_status_control_q <= async_serial_receiver_pkg::RST_TX_STATUS_CONTROL
				& async_serial_receiver_pkg::WMASK_TX_STATUS_CONTROL;
			baud_q <= async_serial_receiver_pkg::RST_BAUD_DIVISOR;
			bvalid_q <= 1'b0;
			bresp_q <= async_serial_receiver_pkg::RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= async_serial_receiver_pkg::RESP_OKAY;
			rdata_q <= 32'h00000000;
		end
		else
		begin
			interrupt_control_q <= interrupt_control_d;
			rx_status_control_q <= rx_status_control_d;
			pie_q <= pie_d;
			tx_status_control_q <= tx_status_control_d;
			baud_q <= baud_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_q <= async_serial_receiver_pkg::ST_IDLE;
			os_q <= 4'h0;
			bits_q <= 4'h0;
			sr_q <= 9'h000;
			prev_q <= 1'b1;
			brg_q <= 8'h00;
			pre_q <= 2'h0;
			overrun_error_q <= 1'b0;
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'h0;
			mem[0] <= 10'h000;
			mem[1] <= 10'h000;
		end
		else
		begin
			st_q <= st_d;
			os_q <= os_d;
			bits_q <= bits_d;
			sr_q <= sr_d;
			prev_q <= prev_d;
			brg_q <= brg_d;
			pre_q <= pre_d;
			overrun_error_q <= overrun_error_d;
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			if (push)
				mem[wp_q] <= push_word;
		end
	end

endmodule

// ### test/async_serial_receiver_sva.sv
`timescale 1ns/10ps
module async_serial_receiver_sva (
	input logic clk,
	input logic srst,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0] s_axi_rresp,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic sleep_mode,
	input logic rx_irq_req
);
	logic wr_take;
	logic rd_take;
	logic bus_take;
	assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign rd_take = s_axi_arvalid && !s_axi_rvalid;
	assign bus_take = wr_take || rd_take;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	AST_WR_ANSWER: assert property (wr_take |=> s_axi_bvalid)
		else $error("write not answered");
	AST_RD_ANSWER: assert property (rd_take |=> s_axi_rvalid)
		else $error("read not answered");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped");
	AST_W_REFUSE: assert property (s_axi_bvalid |-> !(s_axi_awready || s_axi_wready))
		else $error("write taken during response");
	AST_R_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	AST_IRQ_FALL: assert property ($fell(rx_irq_req) |-> $past(bus_take))
		else $error("request fell without access");
	AST_SLEEP_HALT: assert property (
		$rose(rx_irq_req) && $past(sleep_mode) && $past(sleep_mode, 2) |-> $past(wr_take))
		else $error("word received asleep");
endmodule
bind async_serial_receiver async_serial_receiver_sva sva_u (.clk, .srst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.sleep_mode, .rx_irq_req);

// ### test/serial_tx_model.sv
`timescale 1ns/10ps
module serial_tx_model (
	input wire logic clk,
	output logic line
);
	// Line idles high between frames
	initial line = 1'b1;
	// Stop level is an argument so a framing fault can be commanded
	task automatic send(input logic [8:0] d, input int nb, input logic stop, input int bclk);
		for (int i = -1; i <= nb; i++)
		begin
			@(posedge clk);
			line <= (i < 0) ? 1'b0 : (i == nb) ? stop : d[i];
			repeat (bclk - 1) @(posedge clk);
		end
		@(posedge clk);
		line <= 1'b1;
	endtask
endmodule

// ### test/testbench.sv
`timescale 1ns/10ps
module testbench;
	localparam logic [9:0] RCS = async_serial_receiver_pkg::IDX_RX_STATUS_CONTROL;
	localparam logic [9:0] RDB = async_serial_receiver_pkg::IDX_RX_DATA_BUFFER;
	localparam logic [9:0] FLG = async_serial_receiver_pkg::IDX_PERIPHERAL_IRQ_FLAGS;
	localparam logic [9:0] PIE = async_serial_receiver_pkg::IDX_PERIPHERAL_IRQ_ENABLES;
	localparam logic [9:0] TXS = async_serial_receiver_pkg::IDX_TX_STATUS_CONTROL;
	logic clk = 1'b0, srst = 1'b1, sleep_mode = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_irq_req;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	wire serial_rx_pin;
	int mismatches = 0;
	int n_compared = 0;
	always #5 clk = ~clk;
	serial_tx_model tx_u (.clk, .line(serial_rx_pin));
	async_serial_receiver dut_u (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_rx_pin,
		.sleep_mode, .rx_irq_req);
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		@(posedge clk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge clk); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		chk("bresp", {30'h0, s_axi_bresp}, 32'h0);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rc(input string nm, input logic [9:0] idx, input logic [7:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(idx, d, r);
		chk(nm, d, {24'h000000, exp});
		chk("rresp", {30'h0, r}, 32'h0);
	endtask
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		rc("txs", TXS, 8'h02);
		rc("rcs", RCS, 8'h00);
		rc("pie", PIE, 8'h00);
		rc("baud", async_serial_receiver_pkg::IDX_BAUD_DIVISOR, 8'h00);
		rc("interrupt_control", async_serial_receiver_pkg::IDX_INTERRUPT_CONTROL, 8'h00);
		wr(async_serial_receiver_pkg::IDX_INTERRUPT_CONTROL, 8'hc0);
		rc("interrupt_control rw", async_serial_receiver_pkg::IDX_INTERRUPT_CONTROL, 8'hc0);
		wr(FLG, 8'hff);
		rc("flags ro", FLG, 8'h00);
		rd(10'h001, d, r);
		chk("unmapped", {d[29:0], r}, {30'h0, async_serial_receiver_pkg::RESP_SLVERR});
	endtask
	task automatic t_basic;
		wr(TXS, 8'h04);
		wr(PIE, 8'h20);
		wr(RCS, 8'h90);
		tx_u.send(9'h0a5, 8, 1'b1, 16);
		chk("irq", {31'h0, rx_irq_req}, 32'h1);
		rc("flag set", FLG, 8'h20);
		rc("status", RCS, 8'h90);
		rc("data", RDB, 8'ha5);
		rc("flag clr", FLG, 8'h00);
		// Slow generator: four clocks per tick
		wr(TXS, 8'h00);
		tx_u.send(9'h03c, 8, 1'b1, 64);
		rc("slow data", RDB, 8'h3c);
		wr(TXS, 8'h04);
		// Divisor of one: a sample tick every second clock
		wr(async_serial_receiver_pkg::IDX_BAUD_DIVISOR, 8'h01);
		tx_u.send(9'h0c3, 8, 1'b1, 32);
		rc("divided data", RDB, 8'hc3);
		wr(async_serial_receiver_pkg::IDX_BAUD_DIVISOR, 8'h00);
	endtask
	task automatic t_overrun;
		tx_u.send(9'h011, 8, 1'b1, 16);
		tx_u.send(9'h022, 8, 1'b1, 16);
		tx_u.send(9'h033, 8, 1'b1, 16);
		rc("overrun", RCS, 8'h92);
		rc("first", RDB, 8'h11);
		rc("second", RDB, 8'h22);
		tx_u.send(9'h044, 8, 1'b1, 16);
		rc("blocked", FLG, 8'h00);
		wr(RCS, 8'h90);
		rc("overrun_error kept", RCS, 8'h92);
		wr(RCS, 8'h80);
		wr(RCS, 8'h90);
		rc("overrun_error clr", RCS, 8'h90);
	endtask
	task automatic t_ninth;
		wr(RCS, 8'hd0);
		tx_u.send(9'h1c3, 9, 1'b0, 16);
		tx_u.send(9'h05a, 9, 1'b1, 16);
		rc("framing_error ninth", RCS, 8'hd5);
		rc("word1", RDB, 8'hc3);
		rc("advanced", RCS, 8'hd0);
		rc("word2", RDB, 8'h5a);
	endtask
	task automatic t_addr;
		wr(PIE, 8'h00);
		wr(RCS, 8'hd8);
		tx_u.send(9'h0aa, 9, 1'b1, 16);
		rc("dropped", FLG, 8'h00);
		tx_u.send(9'h155, 9, 1'b1, 16);
		chk("irq gated", {31'h0, rx_irq_req}, 32'h0);
		rc("addr flag", FLG, 8'h20);
		rc("addr", RDB, 8'h55);
		wr(RCS, 8'hd0);
		tx_u.send(9'h066, 9, 1'b1, 16);
		rc("data in", RDB, 8'h66);
	endtask
	task automatic t_off;
		// Request enabled so a word taken while asleep would show on the pin
		wr(PIE, 8'h20);
		wr(RCS, 8'h80);
		tx_u.send(9'h077, 8, 1'b1, 16);
		rc("disabled", FLG, 8'h00);
		wr(TXS, 8'h14);
		wr(RCS, 8'h90);
		tx_u.send(9'h07e, 8, 1'b1, 16);
		rc("sync mode", FLG, 8'h00);
		wr(TXS, 8'h04);
		@(posedge clk);
		sleep_mode <= 1'b1;
		tx_u.send(9'h088, 8, 1'b1, 16);
		rc("asleep", FLG, 8'h00);
		sleep_mode <= 1'b0;
		tx_u.send(9'h099, 8, 1'b1, 16);
		rc("awake", RDB, 8'h99);
	endtask
	task automatic end_sim;
		if (mismatches == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Run needs about 3500 cycles; limit leaves wide margin
	initial
	begin
		#400000;
		mismatches++;
		end_sim;
	end
	initial
	begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		t_reset;
		t_basic;
		t_overrun;
		t_ninth;
		t_addr;
		t_off;
		end_sim;
	end
endmodule
